/* dsfp_params.svh */
`ifndef DSFP_PARAMS_SVH
`define DSFP_PARAMS_SVH
`define DSFP_MULTI_PHASES 6
`define DSFP_SYNC_STAGES 2
// thresholds and levels in millivolts
`define DSFP_REF_FLOOR_MV 16'd250
// nominal reference, 1200 mV, used at reset and after an enable cycle
`define DSFP_REF_NOMINAL_MV 16'h04B0
`define DSFP_OC_FULL_MV 16'd2500
`define DSFP_OC_N3_MV 16'd1650
`define DSFP_OC_N4_MV 16'd1250
`define DSFP_OC_N5_MV 16'd1000
`define DSFP_OC_N6_MV 16'd830
`define DSFP_SINGLE_CURRENT_MONITOR_OC_MV 16'd1550
`define DSFP_IMAX_MV 16'd1240
`define DSFP_REDUCED_MAX_PHASES 3'd2
// overvoltage ramp step in millivolts per clock, and post-transition mask delay
`define DSFP_RAMP_STEP_MV 16'd1
`define DSFP_MASK_DELAY_NS 1000
`define DSFP_CLK_PERIOD_NS 10
`define DSFP_MASK_DELAY_CYC ((`DSFP_MASK_DELAY_NS + `DSFP_CLK_PERIOD_NS - 1) / `DSFP_CLK_PERIOD_NS)
// power state codes
`define DSFP_PS_FULL 8'h00
`define DSFP_PS_LIGHT1 8'h01
`define DSFP_PS_LIGHT2 8'h02
`endif

/* dsfp_pkg.sv */
package dsfp_pkg;
  typedef enum logic [1:0] {
    DSFP_RUN = 2'b00,
    DSFP_OV_RAMP = 2'b01,
    DSFP_OV_DONE = 2'b10,
    DSFP_OC_LATCH = 2'b11
  } dsfp_state_t;

  // per-phase drive: enable low means the pin is high impedance
  typedef struct packed {
    logic [5:0] multi_level;
    logic [5:0] multi_oe;
    logic single_level;
    logic single_oe;
    logic multi_drv_en;
    logic single_drv_en;
  } dsfp_drive_t;

  typedef struct packed {
    logic multi_ov;
    logic single_ov;
    logic multi_below_floor;
    logic single_below_floor;
    logic [5:0] multi_info_oc;
    logic single_info_oc;
    logic ramp_active;
  } dsfp_cmp_t;
endpackage

/* dsfp_sync.sv */
`timescale 1ns/1ps
module dsfp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  // meta_reg feeds only q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* dsfp_protect.sv */
`timescale 1ns/1ps
`include "dsfp_params.svh"
// Function
// - overvoltage in a section starts protection and ramps its reference toward 250 mV
// - during ramp, offending phases alternate tri-state and low, driver enable high
// - offending section output below 250 mV puts all its phases tri-state
// - other section tri-stated permanently with its driver enable low
// - overvoltage drives the fault indicator pin high
// - fault stays latched until supply or enable is cycled
// - ramp finishes even if cause clears, then all phases tri-state
// - phase info current over 35 uA turns its low-side switch on meanwhile
// - total current sense over 2.5 V latches overcurrent, all phases tri-state
// - single current monitor over 1.55 V latches overcurrent, all tri-state
// - total sense used only for overcurrent; monitor for maximum current reporting and overcurrent
// - monitor at 1.24 V reports maximum current reached
// - power states above full power limit multi section to two phases
// - threshold 2.5 V at full power; 1.65 V for 3 phases in light states
// - light states: 1.25 V for 4, 1.0 V for 5, 0.83 V for 6 phases
// - fault detection masked during reference ramps plus extra delay
// - a section fault clears only that section's ready output
module dsfp_protect (
  clk,
  reset_n,
  enable,
  cmp_in,
  total_current_limit_sense,
  single_current_monitor,
  power_state,
  phases_configured,
  pwm_demand,
  multi_ramp_ready,
  single_ramp_ready,
  phase_pwm_output,
  driver_enable_out,
  fault_indicator_pin,
  regulator_ready,
  overvoltage_fault,
  overcurrent_fault,
  imax_reached,
  active_phase_limit,
  multi_ref_mv,
  single_ref_mv
);
  import dsfp_pkg::*;
  input wire logic clk;
  input wire logic reset_n;
  input wire logic enable;
  input wire dsfp_pkg::dsfp_cmp_t cmp_in;
  input wire logic [15:0] total_current_limit_sense;
  input wire logic [15:0] single_current_monitor;
  input wire logic [7:0] power_state;
  input wire logic [2:0] phases_configured;
  input wire logic [6:0] pwm_demand;
  input wire logic multi_ramp_ready;
  input wire logic single_ramp_ready;
  output dsfp_pkg::dsfp_drive_t phase_pwm_output;
  output logic [1:0] driver_enable_out;
  output logic fault_indicator_pin;
  output logic [1:0] regulator_ready;
  output logic [1:0] overvoltage_fault;
  output logic overcurrent_fault;
  output logic imax_reached;
  output logic [2:0] active_phase_limit;
  output logic [15:0] multi_ref_mv;
  output logic [15:0] single_ref_mv;

  typedef struct packed {
    logic [1:0] rst_sync;
    dsfp_state_t state;
    logic ov_multi;
    logic [15:0] ref_mv;
    logic toggle;
    logic [15:0] mask_cnt;
    logic oc;
    dsfp_drive_t drive;
    logic [1:0] drv_en;
    logic flt;
    logic [1:0] ovf;
    logic [1:0] rdy;
    logic imax;
    logic [2:0] phase_lim;
    logic [15:0] mref;
    logic [15:0] sref;
  } dsfp_regs_t;

  dsfp_regs_t s_reg;
  dsfp_regs_t s_next;
  dsfp_cmp_t cmp_s;
  logic rst_n;
  logic [15:0] oc_thr;

  assign rst_n = s_reg.rst_sync[1];

  dsfp_sync #(.WIDTH($bits(dsfp_cmp_t))) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(cmp_in),
    .q(cmp_s)
  );

  // threshold lookup, light states scale with configured phase count
  function automatic logic [15:0] oc_level(input logic [7:0] ps, input logic [2:0] n);
    logic [15:0] v;
    v = `DSFP_OC_FULL_MV;
    if (ps == `DSFP_PS_LIGHT1 || ps == `DSFP_PS_LIGHT2) begin
      unique case (n)
        3'd3: v = `DSFP_OC_N3_MV;
        3'd4: v = `DSFP_OC_N4_MV;
        3'd5: v = `DSFP_OC_N5_MV;
        3'd6: v = `DSFP_OC_N6_MV;
        default: v = `DSFP_OC_FULL_MV;
      endcase
    end
    return v;
  endfunction

  always_comb begin
    logic masked;
    logic ov_hit;
    logic oc_hit;
    logic off_floor;
    masked = 1'b0;
    ov_hit = 1'b0;
    oc_hit = 1'b0;
    off_floor = 1'b0;
    oc_thr = oc_level(power_state, phases_configured);
    s_next = s_reg;
    s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
    s_next.toggle = ~s_reg.toggle;
    // extra delay after every ramp so the settling edge cannot trip
    if (cmp_s.ramp_active) begin
      s_next.mask_cnt = 16'(`DSFP_MASK_DELAY_CYC);
    end else if (s_reg.mask_cnt != 16'h0000) begin
      s_next.mask_cnt = s_reg.mask_cnt - 16'h0001;
    end
    masked = cmp_s.ramp_active || (s_reg.mask_cnt != 16'h0000);
    ov_hit = !masked && (cmp_s.multi_ov || cmp_s.single_ov);
    // total sense feeds this compare and the ready choice; monitor feeds its own and the imax flag
    oc_hit = !masked && ((total_current_limit_sense >= oc_thr) ||
             (single_current_monitor >= `DSFP_SINGLE_CURRENT_MONITOR_OC_MV));
    s_next.imax = single_current_monitor >= `DSFP_IMAX_MV;
    s_next.phase_lim = (power_state != `DSFP_PS_FULL) ? `DSFP_REDUCED_MAX_PHASES : phases_configured;
    if (!enable) begin
      s_next.state = DSFP_RUN;
      s_next.oc = 1'b0;
      s_next.flt = 1'b0;
      s_next.drive = '0;
      s_next.drv_en = 2'b00;
      s_next.rdy = 2'b00;
    end else begin
      unique case (s_reg.state)
        DSFP_RUN: begin
          s_next.rdy = 2'b11;
          s_next.drv_en = 2'b11;
          s_next.drive.multi_oe = 6'h3F;
          s_next.drive.single_oe = 1'b1;
          for (int i = 0; i < `DSFP_MULTI_PHASES; i++) begin
            // beyond the phase limit a phase is parked in tri-state
            s_next.drive.multi_oe[i] = (3'(i) < s_next.phase_lim);
            s_next.drive.multi_level[i] = pwm_demand[i] && !cmp_s.multi_info_oc[i];
          end
          s_next.drive.single_level = pwm_demand[6] && !cmp_s.single_info_oc;
          if (ov_hit) begin
            s_next.state = DSFP_OV_RAMP;
            s_next.ov_multi = cmp_s.multi_ov;
            s_next.ref_mv = cmp_s.multi_ov ? multi_ref_mv : single_ref_mv;
            s_next.flt = 1'b1;
            // the other section goes quiet on the very first fault edge, not one cycle later
            s_next.drive = '0;
            s_next.drv_en = cmp_s.multi_ov ? 2'b01 : 2'b10;
            s_next.rdy = cmp_s.multi_ov ? 2'b01 : 2'b10;
          end else if (oc_hit) begin
            s_next.state = DSFP_OC_LATCH;
            s_next.oc = 1'b1;
            s_next.drive = '0;
            s_next.drv_en = 2'b00;
            s_next.rdy = (total_current_limit_sense >= oc_thr) ? 2'b01 : 2'b10;
          end
        end
        DSFP_OV_RAMP: begin
          off_floor = s_reg.ov_multi ? !cmp_s.multi_below_floor : !cmp_s.single_below_floor;
          s_next.drive.multi_level = '0;
          s_next.drive.single_level = 1'b0;
          if (s_reg.ov_multi) begin
            s_next.drive.multi_oe = (off_floor && s_reg.toggle) ? 6'h3F : 6'h00;
            s_next.drive.single_oe = 1'b0;
            s_next.drv_en = 2'b01;
          end else begin
            s_next.drive.single_oe = off_floor && s_reg.toggle;
            s_next.drive.multi_oe = 6'h00;
            s_next.drv_en = 2'b10;
          end
          // ramp keeps going even if the overvoltage has cleared
          if (s_reg.ref_mv > `DSFP_REF_FLOOR_MV) begin
            s_next.ref_mv = s_reg.ref_mv - `DSFP_RAMP_STEP_MV;
          end else begin
            s_next.state = DSFP_OV_DONE;
            s_next.drive = '0;
          end
        end
        DSFP_OV_DONE: begin
          s_next.drive = '0;
        end
        DSFP_OC_LATCH: begin
          s_next.drive = '0;
          s_next.drv_en = 2'b00;
        end
      endcase
    end
    // reference tracks the ramp only in overvoltage; an enable cycle restores nominal
    s_next.ovf = 2'b00;
    s_next.mref = enable ? multi_ref_mv : `DSFP_REF_NOMINAL_MV;
    s_next.sref = enable ? single_ref_mv : `DSFP_REF_NOMINAL_MV;
    if (s_next.state == DSFP_OV_RAMP || s_next.state == DSFP_OV_DONE) begin
      s_next.ovf = {s_next.ov_multi, !s_next.ov_multi};
      if (s_next.ov_multi) begin
        s_next.mref = s_next.ref_mv;
      end else begin
        s_next.sref = s_next.ref_mv;
      end
    end
  end

  // the ready/fault outputs are only released by enable going low or by reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{rst_sync: 2'b00, state: DSFP_RUN, ref_mv: 16'h0000, mask_cnt: 16'h0000,
                 drive: '0, mref: `DSFP_REF_NOMINAL_MV, sref: `DSFP_REF_NOMINAL_MV, default: '0};
    end else if (!rst_n) begin
      s_reg <= '{rst_sync: s_next.rst_sync, state: DSFP_RUN, ref_mv: 16'h0000, mask_cnt: 16'h0000,
                 drive: '0, mref: `DSFP_REF_NOMINAL_MV, sref: `DSFP_REF_NOMINAL_MV, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign phase_pwm_output = s_reg.drive;
  assign driver_enable_out = s_reg.drv_en;
  assign fault_indicator_pin = s_reg.flt;
  assign regulator_ready = s_reg.rdy;
  assign overvoltage_fault = s_reg.ovf;
  assign overcurrent_fault = s_reg.oc;
  assign imax_reached = s_reg.imax;
  assign active_phase_limit = s_reg.phase_lim;
  assign multi_ref_mv = s_reg.mref;
  assign single_ref_mv = s_reg.sref;

  sequence ov_seen_s;
    s_reg.state == DSFP_RUN && s_next.state == DSFP_OV_RAMP;
  endsequence

  a_ov_flag_set: assert property (@(posedge clk) disable iff (!rst_n) ov_seen_s |=> fault_indicator_pin)
    else $error("fault pin not raised on overvoltage");
  a_ov_latched: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_indicator_pin && enable) |=> fault_indicator_pin)
    else $error("fault pin dropped while enabled");
  a_ov_other_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.state == DSFP_OV_RAMP && s_reg.ov_multi) |->
    (!phase_pwm_output.single_oe && driver_enable_out == 2'b01))
    else $error("other section not tri-stated");
  a_ov_done_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.state == DSFP_OV_DONE) |-> (phase_pwm_output.multi_oe == 6'h00 && !phase_pwm_output.single_oe))
    else $error("phases driven after ramp end");
  a_oc_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    overcurrent_fault |-> (phase_pwm_output.multi_oe == 6'h00 && driver_enable_out == 2'b00))
    else $error("phases driven during overcurrent");
  a_ramp_down: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.state == DSFP_OV_RAMP && s_reg.ref_mv > `DSFP_REF_FLOOR_MV && enable) |=>
    s_reg.ref_mv < $past(s_reg.ref_mv))
    else $error("reference not ramping down");
  a_limit_light: assert property (@(posedge clk) disable iff (!rst_n)
    (power_state != `DSFP_PS_FULL) |=> active_phase_limit == `DSFP_REDUCED_MAX_PHASES)
    else $error("phase limit not applied");
  a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_s.ramp_active |=> s_reg.mask_cnt == 16'(`DSFP_MASK_DELAY_CYC))
    else $error("mask delay not loaded");
  a_ready_one: assert property (@(posedge clk) disable iff (!rst_n)
    (ov_seen_s ##0 cmp_s.multi_ov) |=> regulator_ready == 2'b01)
    else $error("wrong ready dropped");
  a_floor_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.state == DSFP_OV_RAMP && s_reg.ov_multi && cmp_s.multi_below_floor) |=>
    (phase_pwm_output.multi_oe == 6'h00))
    else $error("phases driven below floor");
  a_info_low: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.state == DSFP_RUN && enable && cmp_s.single_info_oc) |=> !phase_pwm_output.single_level)
    else $error("phase driven high over current limit");
endmodule

/* dsfp_stage_model.sv */
`timescale 1ns/1ps
module dsfp_stage_model (
  drive,
  pin_level,
  low_side_on
);
  import dsfp_pkg::*;
  input wire dsfp_pkg::dsfp_drive_t drive;
  output logic [6:0] pin_level;
  output logic [6:0] low_side_on;
  logic [6:0] oe;
  logic [6:0] lvl;
  logic [6:0] last = 7'h00;
  assign oe = {drive.single_oe, drive.multi_oe};
  assign lvl = {drive.single_level, drive.multi_level};
  // a driven low pin turns the lower switch on
  assign low_side_on = oe & ~lvl;
  always @(oe or lvl) begin
    for (int i = 0; i < 7; i++) begin
      if (oe[i]) begin
        last[i] = lvl[i];
      end
    end
  end
  // a released pin floats: show the inverse of its last level so it never reads as still driven
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_level[i] = oe[i] ? lvl[i] : ~last[i];
    end
  end
endmodule

/* dsfp_protect_tb.sv */
`timescale 1ns/1ps
module dsfp_protect_tb;
  import dsfp_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic enable = 1'b0;
  dsfp_cmp_t cmp_in = '0;
  logic [15:0] tot_sense = 16'h0000;
  logic [15:0] mon = 16'h0000;
  logic [7:0] power_state = 8'h00;
  logic [2:0] phases = 3'h6;
  logic [6:0] pwm_demand = 7'h7F;
  dsfp_drive_t drive;
  logic [1:0] drv_en;
  logic [1:0] ready;
  logic [1:0] ov_fault;
  logic flt_pin, oc_fault, imax;
  logic [2:0] ph_limit;
  logic [15:0] mref, sref;
  logic [6:0] pin_level, low_side_on;
  integer seed;
  int err_total = 0;
  int tests_run = 0;
  int idx;
  int hits = 0;
  logic [31:0] exp_q[$];
  int sel_q[$];
  event chk_ev;

  always #5 clk = ~clk;

  dsfp_protect dsfp_protect_inst (.clk(clk), .reset_n(reset_n), .enable(enable), .cmp_in(cmp_in),
    .total_current_limit_sense(tot_sense), .single_current_monitor(mon), .power_state(power_state),
    .phases_configured(phases), .pwm_demand(pwm_demand), .multi_ramp_ready(1'b0),
    .single_ramp_ready(1'b0), .phase_pwm_output(drive), .driver_enable_out(drv_en),
    .fault_indicator_pin(flt_pin), .regulator_ready(ready), .overvoltage_fault(ov_fault),
    .overcurrent_fault(oc_fault), .imax_reached(imax), .active_phase_limit(ph_limit),
    .multi_ref_mv(mref), .single_ref_mv(sref));

  dsfp_stage_model dsfp_stage_model_inst (.drive(drive), .pin_level(pin_level), .low_side_on(low_side_on));

  function automatic logic [31:0] obs(int sel);
    case (sel)
      0: return {29'h0, ph_limit};
      1: return {31'h0, oc_fault};
      2: return {25'h0, flt_pin, drv_en, ready, ov_fault};
      3: return {25'h0, drive.single_oe, drive.multi_oe};
      4: return {31'h0, imax};
      5: return {16'h0, mref};
      6: return {25'h0, low_side_on};
      7: return {30'h0, drive.single_oe, drv_en[1]};
      9: return 32'(hits);
      10: return {16'h0, sref};
      11: return {25'h0, pin_level};
      default: return {31'h0, |(drive.multi_oe & drive.multi_level)};
    endcase
  endfunction

  function automatic logic [15:0] thr(logic [7:0] ps, logic [2:0] n);
    if (ps == 8'h00) return 16'd2500;
    case (n)
      3'h3: return 16'd1650;
      3'h4: return 16'd1250;
      3'h5: return 16'd1000;
      default: return 16'd830;
    endcase
  endfunction

  task automatic note(int sel, logic [31:0] expv);
    sel_q.push_back(sel);
    exp_q.push_back(expv);
    -> chk_ev;
  endtask

  // second process: compares each note against the outputs as they stand now
  always @(chk_ev) begin
    while (exp_q.size() > 0) begin
      logic [31:0] e;
      logic [31:0] g;
      e = exp_q.pop_front();
      g = obs(sel_q.pop_front());
      tests_run++;
      if (g !== e) begin
        err_total++;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  end

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic restart;
    enable = 1'b0;
    cyc(2);
    enable = 1'b1;
    cyc(4);
    note(1, 0);
    note(2, 32'h3C);
    note(5, 32'd1200);
  endtask

  task automatic print_verdict;
    // let the compare process drain notes queued in this same time step
    #1;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    print_verdict();
  end

  initial begin
    seed = 32'hB2AEF1A1;
    cyc(8);
    reset_n = 1'b1;
    enable = 1'b1;
    cyc(4);
    note(1, 0);
    for (int ps = 0; ps < 3; ps++) begin
      for (int n = 3; n < 7; n++) begin
        power_state = ps[7:0];
        phases = n[2:0];
        tot_sense = thr(ps[7:0], n[2:0]) - 16'd1 - 16'({$random(seed)} % 8);
        cyc(4);
        note(0, (ps == 0) ? n : 2);
        note(1, 0);
        tot_sense = thr(ps[7:0], n[2:0]) + 16'd1;
        cyc(4);
        note(1, 1);
        note(3, 0);
        note(4, 0);
        tot_sense = 16'h0000;
        cyc(3);
        note(1, 1);
        restart();
      end
    end
    power_state = 8'h00;
    phases = 3'h6;
    mon = 16'd1239;
    cyc(4);
    note(4, 0);
    mon = 16'd1549;
    cyc(4);
    note(4, 1);
    note(1, 0);
    mon = 16'd1551;
    cyc(4);
    note(1, 1);
    note(3, 0);
    mon = 16'h0000;
    restart();
    pwm_demand = 7'h7F;
    idx = {$random(seed)} % 6;
    cmp_in.multi_info_oc[idx] = 1'b1;
    cmp_in.single_info_oc = 1'b1;
    cyc(4);
    note(6, 32'h40 | (32'h1 << idx));
    note(11, 32'h3F & ~(32'h1 << idx));
    cmp_in.multi_info_oc = 6'h00;
    cmp_in.single_info_oc = 1'b0;
    cyc(4);
    note(6, 0);
    cmp_in.ramp_active = 1'b1;
    cyc(3);
    tot_sense = 16'd3000;
    cyc(10);
    note(1, 0);
    cmp_in.ramp_active = 1'b0;
    // two synchroniser edges, then a hundred masked edges, then the latch
    cyc(102);
    note(1, 0);
    cyc(1);
    note(1, 1);
    tot_sense = 16'h0000;
    restart();
    cmp_in.multi_ov = 1'b1;
    cyc(4);
    note(2, 32'h56);
    note(7, 0);
    for (int k = 0; k < 40; k++) begin
      cyc(1);
      note(8, 0);
      hits = hits + ((drive.multi_oe == 6'h3F) ? 1 : 0);
    end
    // strict alternation between driven low and released gives half the samples driven
    note(9, 20);
    cmp_in.multi_ov = 1'b0;
    cmp_in.multi_below_floor = 1'b1;
    cyc(4);
    note(3, 0);
    cmp_in.multi_below_floor = 1'b0;
    cyc(1000);
    note(5, 250);
    note(10, 32'd1200);
    note(3, 0);
    note(2, 32'h56);
    restart();
    print_verdict();
  end
endmodule
